// ---- core/iolc_core.sv ----
// iolc_core: per-line control core of a 32-line I/O controller with
// pull resistor control, four-way peripheral multiplexing, output
// control with masked direct writes, open-drain and pin sampling.
// assumes: a single-master register port with one-cycle strobes and
// read data in the cycle after the read strobe; pad_in is asynchronous.
//
// Functional notes
// - pull-up enable clears, disable sets status
// - pull-down enable clears, disable sets status
// - pull-down enable ignored while pull-up active
// - pull-up enable ignored while pull-down active
// - reset: pull-ups on, pull-downs off except on lines 28-31
// - own enable sets, disable clears ownership
// - unmuxed lines ignore ownership writes, read one
// - ownership reset value is an integration parameter
// - two select bits choose peripheral A to D
// - selection steers outputs; inputs always see pin
// - select resets to A, owned lines undriven
// - select writable anytime; handover needs both writes
// - peripheral-owned pins driven by chosen function
// - output enable set/clear, one means driven
// - level set/clear, updates even when peripheral owns
// - direct level write touches only masked bits
// - write mask resets to zero
// - open-drain lines only pull low
// - open-drain set/clear, applies to any owner
// - open-drain resets disabled
// - pin level status reports actual pad level
// - sampled on clock, held while clock stopped
// - line n maps to bit n everywhere
// - config writes work with sampling clock off
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module iolc_core
  import iolc_pkg::*;
#(
  parameter logic [31:0] OWN_RESET = iolc_pkg::RST_OWN,
  parameter logic [31:0] MUXED     = iolc_pkg::RST_MUXED
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic                   samp_clk_en,
  input  wire iolc_pkg::iolc_bus_req_t bus_req,
  output var  logic [31:0]            bus_rdata,
  input  wire iolc_pkg::iolc_periph_t [iolc_pkg::NFUNC-1:0] periph_drv,
  output var  logic [iolc_pkg::NLINES-1:0] periph_in,
  input  wire logic [iolc_pkg::NLINES-1:0] pad_in,
  output var  iolc_pkg::iolc_pad_t    pad_ctl
);

  import iolc_pkg::*;

  // configuration state, line n in bit n throughout
  logic [NLINES-1:0] pu_off_ff;           // pullup_off_status
  logic [NLINES-1:0] pd_off_ff;           // pulldown_off_status
  logic [NLINES-1:0] own_ff;              // gpio_own_status
  logic [NLINES-1:0] fsel_lo_ff;          // func_select_lo
  logic [NLINES-1:0] fsel_hi_ff;          // func_select_hi
  logic [NLINES-1:0] oe_ff;               // out_enable_status
  logic [NLINES-1:0] lvl_ff;              // out_level_status
  logic [NLINES-1:0] mask_ff;             // out_write_mask_status
  logic [NLINES-1:0] od_ff;               // open_drain_status
  logic [NLINES-1:0] nxt_pu_off;
  logic [NLINES-1:0] nxt_pd_off;
  logic [NLINES-1:0] nxt_own;
  logic [NLINES-1:0] nxt_fsel_lo;
  logic [NLINES-1:0] nxt_fsel_hi;
  logic [NLINES-1:0] nxt_oe;
  logic [NLINES-1:0] nxt_lvl;
  logic [NLINES-1:0] nxt_mask;
  logic [NLINES-1:0] nxt_od;

  // sampled pin state
  logic [NLINES-1:0] pad_sync;
  logic [NLINES-1:0] pin_lvl_ff;          // pin_level_status
  logic [NLINES-1:0] nxt_pin_lvl;

  // read path
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;

  // pad drive
  logic [NLINES-1:0] drv_out;
  logic [NLINES-1:0] drv_oe;
  logic [NLINES-1:0] pad_out_ff;
  logic [NLINES-1:0] pad_oe_ff;
  logic [NLINES-1:0] nxt_pad_out;
  logic [NLINES-1:0] nxt_pad_oe;

  logic wr;
  logic [31:0] wd;

  assign wr = bus_req.wr;
  assign wd = bus_req.wdata;

  // one-hot write hits, one per writable offset; an unmapped or
  // read-only offset raises none, so such a write changes nothing
  logic hit_pu_en;
  logic hit_pu_dis;
  logic hit_pd_en;
  logic hit_pd_dis;
  logic hit_own_en;
  logic hit_own_dis;
  logic hit_fsel_lo;
  logic hit_fsel_hi;
  logic hit_oe_en;
  logic hit_oe_dis;
  logic hit_out_set;
  logic hit_out_clr;
  logic hit_out_lvl;
  logic hit_mask_en;
  logic hit_mask_dis;
  logic hit_od_en;
  logic hit_od_dis;

  always_comb begin
    hit_pu_en    = 1'b0;
    hit_pu_dis   = 1'b0;
    hit_pd_en    = 1'b0;
    hit_pd_dis   = 1'b0;
    hit_own_en   = 1'b0;
    hit_own_dis  = 1'b0;
    hit_fsel_lo  = 1'b0;
    hit_fsel_hi  = 1'b0;
    hit_oe_en    = 1'b0;
    hit_oe_dis   = 1'b0;
    hit_out_set  = 1'b0;
    hit_out_clr  = 1'b0;
    hit_out_lvl  = 1'b0;
    hit_mask_en  = 1'b0;
    hit_mask_dis = 1'b0;
    hit_od_en    = 1'b0;
    hit_od_dis   = 1'b0;
    if (wr) begin
      unique case (bus_req.addr)
        OFS_PU_EN:    hit_pu_en    = 1'b1;
        OFS_PU_DIS:   hit_pu_dis   = 1'b1;
        OFS_PD_EN:    hit_pd_en    = 1'b1;
        OFS_PD_DIS:   hit_pd_dis   = 1'b1;
        OFS_OWN_EN:   hit_own_en   = 1'b1;
        OFS_OWN_DIS:  hit_own_dis  = 1'b1;
        OFS_FSEL_LO:  hit_fsel_lo  = 1'b1;
        OFS_FSEL_HI:  hit_fsel_hi  = 1'b1;
        OFS_OE_EN:    hit_oe_en    = 1'b1;
        OFS_OE_DIS:   hit_oe_dis   = 1'b1;
        OFS_OUT_SET:  hit_out_set  = 1'b1;
        OFS_OUT_CLR:  hit_out_clr  = 1'b1;
        OFS_OUT_LVL:  hit_out_lvl  = 1'b1;
        OFS_MASK_EN:  hit_mask_en  = 1'b1;
        OFS_MASK_DIS: hit_mask_dis = 1'b1;
        OFS_OD_EN:    hit_od_en    = 1'b1;
        OFS_OD_DIS:   hit_od_dis   = 1'b1;
        default: begin
          // read-only or unmapped offset: no hit
        end
      endcase
    end
  end

  // configuration writes; these run on sys_clk and never wait for
  // samp_clk_en, so software can set lines up with sampling off
  always_comb begin
    nxt_pu_off  = pu_off_ff;
    nxt_pd_off  = pd_off_ff;
    nxt_own     = own_ff;
    nxt_fsel_lo = fsel_lo_ff;
    nxt_fsel_hi = fsel_hi_ff;
    nxt_oe      = oe_ff;
    nxt_lvl     = lvl_ff;
    nxt_mask    = mask_ff;
    nxt_od      = od_ff;
    // pull-up enable is dropped on lines whose pull-down is on
    if (hit_pu_en)    nxt_pu_off  = pu_off_ff & ~(wd & pd_off_ff);
    if (hit_pu_dis)   nxt_pu_off  = pu_off_ff | wd;
    // pull-down enable is dropped on lines whose pull-up is on
    if (hit_pd_en)    nxt_pd_off  = pd_off_ff & ~(wd & pu_off_ff);
    if (hit_pd_dis)   nxt_pd_off  = pd_off_ff | wd;
    // lines with no peripheral keep the controller as owner
    if (hit_own_en)   nxt_own     = own_ff | wd;
    if (hit_own_dis)  nxt_own     = own_ff & ~(wd & MUXED);
    // select is accepted whatever the line's owner is
    if (hit_fsel_lo)  nxt_fsel_lo = wd;
    if (hit_fsel_hi)  nxt_fsel_hi = wd;
    // enable and level update regardless of owner
    if (hit_oe_en)    nxt_oe      = oe_ff | wd;
    if (hit_oe_dis)   nxt_oe      = oe_ff & ~wd;
    if (hit_out_set)  nxt_lvl     = lvl_ff | wd;
    if (hit_out_clr)  nxt_lvl     = lvl_ff & ~wd;
    // direct write: only lines with their mask bit set change
    if (hit_out_lvl) begin
      nxt_lvl = (lvl_ff & ~mask_ff) | (wd & mask_ff);
    end
    if (hit_mask_en)  nxt_mask    = mask_ff | wd;
    if (hit_mask_dis) nxt_mask    = mask_ff & ~wd;
    if (hit_od_en)    nxt_od      = od_ff | wd;
    if (hit_od_dis)   nxt_od      = od_ff & ~wd;
  end

  // reset values: pulls, select, mask and open-drain fixed; owner
  // taken from the integration parameters, forced to one on unmuxed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pu_off_ff  <= RST_PU_OFF;
      pd_off_ff  <= RST_PD_OFF;
      own_ff     <= OWN_RESET | ~MUXED;
      fsel_lo_ff <= RST_ZERO;
      fsel_hi_ff <= RST_ZERO;
      oe_ff      <= RST_ZERO;
      lvl_ff     <= RST_ZERO;
      mask_ff    <= RST_ZERO;
      od_ff      <= RST_ZERO;
    end else begin
      pu_off_ff  <= nxt_pu_off;
      pd_off_ff  <= nxt_pd_off;
      own_ff     <= nxt_own;
      fsel_lo_ff <= nxt_fsel_lo;
      fsel_hi_ff <= nxt_fsel_hi;
      oe_ff      <= nxt_oe;
      lvl_ff     <= nxt_lvl;
      mask_ff    <= nxt_mask;
      od_ff      <= nxt_od;
    end
  end

  // pad input through three stages before it is trusted
  iolc_sync #(
    .W        (NLINES)
  ) u_pad_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (pad_in),
    .level    (pad_sync)
  );

  // pin status follows the pad only while sampling is enabled, and
  // keeps the last captured levels while it is stopped
  always_comb begin
    nxt_pin_lvl = pin_lvl_ff;
    if (samp_clk_en) begin
      nxt_pin_lvl = pad_sync;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_lvl_ff <= RST_ZERO;
    end else begin
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  // peripheral inputs see the raw pad whatever is selected; this is
  // a plain wire so the peripheral's own sampling is not delayed
  assign periph_in = pad_in;

  // per-line drive source: controller or the selected function; the
  // select only ever steers out and oe, never the input path
  always_comb begin
    drv_out = '0;
    drv_oe  = '0;
    for (int i = 0; i < NLINES; i++) begin
      if (own_ff[i]) begin
        // controller owns: no peripheral function reaches the pin
        drv_out[i] = lvl_ff[i];
        drv_oe[i]  = oe_ff[i];
      end else begin
        unique case (iolc_func_t'({fsel_hi_ff[i], fsel_lo_ff[i]}))
          IOLC_FUNC_A: begin
            drv_out[i] = periph_drv[0].out[i];
            drv_oe[i]  = periph_drv[0].oe[i];
          end
          IOLC_FUNC_B: begin
            drv_out[i] = periph_drv[1].out[i];
            drv_oe[i]  = periph_drv[1].oe[i];
          end
          IOLC_FUNC_C: begin
            drv_out[i] = periph_drv[2].out[i];
            drv_oe[i]  = periph_drv[2].oe[i];
          end
          IOLC_FUNC_D: begin
            drv_out[i] = periph_drv[3].out[i];
            drv_oe[i]  = periph_drv[3].oe[i];
          end
        endcase
      end
    end
  end

  // open-drain: drive only when the wanted level is low, output zero;
  // a high is left to the pull-up so several drivers can share a line
  always_comb begin
    nxt_pad_out = drv_out & ~od_ff;
    nxt_pad_oe  = drv_oe & ~(od_ff & drv_out);
  end

  // registered pad drive gives glitch-free outputs at a one-cycle
  // cost on the peripheral path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pad_out_ff <= RST_ZERO;
      pad_oe_ff  <= RST_ZERO;
    end else begin
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff  <= nxt_pad_oe;
    end
  end

  always_comb begin
    pad_ctl.out   = pad_out_ff;
    pad_ctl.oe    = pad_oe_ff;
    pad_ctl.pu_en = ~pu_off_ff;
    pad_ctl.pd_en = ~pd_off_ff;
  end

  // read mux; write-only offsets and holes read as zero, data is
  // valid only in the cycle after the read strobe
  always_comb begin
    nxt_rdata = RD_UNMAPPED;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_PU_STS:   nxt_rdata = pu_off_ff;
        OFS_PD_STS:   nxt_rdata = pd_off_ff;
        OFS_OWN_STS:  nxt_rdata = own_ff;
        OFS_FSEL_LO:  nxt_rdata = fsel_lo_ff;
        OFS_FSEL_HI:  nxt_rdata = fsel_hi_ff;
        OFS_OE_STS:   nxt_rdata = oe_ff;
        OFS_OUT_LVL:  nxt_rdata = lvl_ff;
        OFS_MASK_STS: nxt_rdata = mask_ff;
        OFS_OD_STS:   nxt_rdata = od_ff;
        OFS_PIN_LVL:  nxt_rdata = pin_lvl_ff;
        default:      nxt_rdata = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= RST_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule : iolc_core
`default_nettype wire

// ---- core/iolc_pkg.sv ----
// iolc_pkg: constants, register offsets and carrier types for the
// 32-line I/O line controller core.
// assumes: one 200 MHz clock, byte addresses on an 8-bit register port.
package iolc_pkg;

  localparam int unsigned NLINES  = 32;
  localparam int unsigned AW      = 8;
  localparam int unsigned NFUNC   = 4;
  localparam int unsigned SYNC_FF = 3;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [AW-1:0] OFS_OWN_EN     = 8'h00;
  localparam logic [AW-1:0] OFS_OWN_DIS    = 8'h04;
  localparam logic [AW-1:0] OFS_OWN_STS    = 8'h08;
  localparam logic [AW-1:0] OFS_OE_EN      = 8'h10;
  localparam logic [AW-1:0] OFS_OE_DIS     = 8'h14;
  localparam logic [AW-1:0] OFS_OE_STS     = 8'h18;
  localparam logic [AW-1:0] OFS_OUT_SET    = 8'h30;
  localparam logic [AW-1:0] OFS_OUT_CLR    = 8'h34;
  localparam logic [AW-1:0] OFS_OUT_LVL    = 8'h38;
  localparam logic [AW-1:0] OFS_PIN_LVL    = 8'h3C;
  localparam logic [AW-1:0] OFS_OD_EN      = 8'h50;
  localparam logic [AW-1:0] OFS_OD_DIS     = 8'h54;
  localparam logic [AW-1:0] OFS_OD_STS     = 8'h58;
  localparam logic [AW-1:0] OFS_PU_DIS     = 8'h60;
  localparam logic [AW-1:0] OFS_PU_EN      = 8'h64;
  localparam logic [AW-1:0] OFS_PU_STS     = 8'h68;
  localparam logic [AW-1:0] OFS_FSEL_LO    = 8'h70;
  localparam logic [AW-1:0] OFS_FSEL_HI    = 8'h74;
  localparam logic [AW-1:0] OFS_PD_DIS     = 8'h90;
  localparam logic [AW-1:0] OFS_PD_EN      = 8'h94;
  localparam logic [AW-1:0] OFS_PD_STS     = 8'h98;
  localparam logic [AW-1:0] OFS_MASK_EN    = 8'hA0;
  localparam logic [AW-1:0] OFS_MASK_DIS   = 8'hA4;
  localparam logic [AW-1:0] OFS_MASK_STS   = 8'hA8;

  // reset values
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [31:0] RST_PU_OFF   = 32'h0000_0000;
  localparam logic [31:0] RST_PD_OFF   = 32'h0FFF_FFFF;
  localparam logic [31:0] RST_OWN      = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_MUXED    = 32'hFFFF_FFFF;
  localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

  // function codes formed as {hi, lo}
  typedef enum logic [1:0] {
    IOLC_FUNC_A = 2'b00,
    IOLC_FUNC_B = 2'b01,
    IOLC_FUNC_C = 2'b10,
    IOLC_FUNC_D = 2'b11
  } iolc_func_t;

  // register port request, all fields valid in the strobe cycle
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } iolc_bus_req_t;

  // one peripheral function's drive for all lines
  typedef struct packed {
    logic [NLINES-1:0] out;
    logic [NLINES-1:0] oe;
  } iolc_periph_t;

  // pad controls for all lines
  typedef struct packed {
    logic [NLINES-1:0] out;
    logic [NLINES-1:0] oe;
    logic [NLINES-1:0] pu_en;
    logic [NLINES-1:0] pd_en;
  } iolc_pad_t;

endpackage : iolc_pkg

// ---- core/iolc_sync.sv ----
// iolc_sync: three-stage synchroniser with agreement filter for a bus
// of independent asynchronous levels.
// assumes: each bit changes slowly relative to the clock.
`timescale 1ns/10ps
`default_nettype none
module iolc_sync #(
  parameter int unsigned W = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] level
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] nxt_level;

  // a bit moves only once stages two and three agree; stage one is
  // read by stage two alone, so metastability never reaches logic
  always_comb begin
    nxt_level = level_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_level[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      level_ff <= '0;
    end else begin
      s1_ff    <= async_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

endmodule : iolc_sync
`default_nettype wire

// ---- test/io_line_controller_core_test.sv ----
// bench: register port scenarios against the core and a pad model
// assumes: line 0 has no peripheral, line 3 peripheral-owned at reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module io_line_controller_core_test;
  import iolc_pkg::*;
  logic                           sys_clk = 1'b0;
  logic                           rstn = 1'b0;
  logic                           samp_clk_en = 1'b1;
  iolc_bus_req_t                  req = '0;
  iolc_periph_t [NFUNC-1:0]       periph_drv;
  logic [NLINES-1:0]              ext_low = '0;
  logic [31:0]                    bus_rdata;
  logic [NLINES-1:0]              periph_in;
  logic [NLINES-1:0]              pad_in;
  iolc_pad_t                      pad_ctl;
  int                             n_mismatch = 0;
  int                             check_count = 0;
  logic [31:0]                    v;
  always #2.5 sys_clk = ~sys_clk;
  iolc_core #(.OWN_RESET(32'hFFFF_FFF7), .MUXED(32'hFFFF_FFFE)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .samp_clk_en(samp_clk_en),
    .bus_req(req), .bus_rdata(bus_rdata), .periph_drv(periph_drv),
    .periph_in(periph_in), .pad_in(pad_in), .pad_ctl(pad_ctl));
  iolc_pads pads_u (.sys_clk(sys_clk), .pad_ctl(pad_ctl),
    .ext_low(ext_low), .pad_in(pad_in));
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  task t_reset;
    rd(OFS_PU_STS, v); `CHK(v, 32'h0)
    rd(OFS_PD_STS, v); `CHK(v, 32'h0FFF_FFFF)
    rd(OFS_OWN_STS, v); `CHK(v, 32'hFFFF_FFF7)
    rd(OFS_FSEL_HI, v); `CHK(v, 32'h0)
    rd(OFS_MASK_STS, v); `CHK(v, 32'h0)
    rd(OFS_OD_STS, v); `CHK(v, 32'h0)
    rd(8'hFC, v); `CHK(v, 32'h0)
  endtask : t_reset
  task t_pull;
    wr(OFS_PD_EN, 32'h1); rd(OFS_PD_STS, v); `CHK(v, 32'h0FFF_FFFF)
    wr(OFS_PU_DIS, 32'h1); wr(OFS_PD_EN, 32'h1);
    rd(OFS_PD_STS, v); `CHK(v, 32'h0FFF_FFFE)
    wr(OFS_PU_EN, 32'h1); rd(OFS_PU_STS, v); `CHK(v, 32'h1)
    wr(OFS_PD_DIS, 32'h1); wr(OFS_PU_EN, 32'h1);
    rd(OFS_PU_STS, v); `CHK(v, 32'h0)
  endtask : t_pull
  task t_func;
    logic [1:0] fc;
    settle; `CHK(pad_ctl.oe[4], 1'b0)
    wr(OFS_OWN_DIS, 32'h11); rd(OFS_OWN_STS, v); `CHK(v, 32'hFFFF_FFE7)
    for (int f = 0; f < 4; f++) begin
      fc = f[1:0];
      wr(OFS_FSEL_LO, {27'h0, fc[0], 4'h0});
      wr(OFS_FSEL_HI, {27'h0, fc[1], 4'h0}); settle;
      `CHK({pad_ctl.oe[4], pad_ctl.out[4]}, {~fc[1], fc[0]})
    end
    wr(OFS_OE_EN, 32'h10); rd(OFS_OE_STS, v); `CHK(v, 32'h10)
  endtask : t_func
  task t_out;
    wr(OFS_OE_EN, 32'h3); wr(OFS_OUT_SET, 32'h3); settle;
    `CHK({pad_ctl.oe[1:0], pad_ctl.out[1:0]}, 4'hF)
    wr(OFS_OUT_CLR, 32'h1); settle; `CHK(pad_ctl.out[1:0], 2'h2)
    wr(OFS_OUT_LVL, 32'hFF); rd(OFS_OUT_LVL, v); `CHK(v, 32'h2)
    wr(OFS_MASK_EN, 32'h4); wr(OFS_OUT_LVL, 32'hFF);
    rd(OFS_OUT_LVL, v); `CHK(v, 32'h6)
    wr(OFS_MASK_DIS, 32'h4); rd(OFS_MASK_STS, v); `CHK(v, 32'h0)
  endtask : t_out
  task t_od;
    wr(OFS_OD_EN, 32'h2); settle;
    `CHK({pad_ctl.oe[1], pad_ctl.out[1]}, 2'h0)
    wr(OFS_OUT_CLR, 32'h2); settle;
    `CHK({pad_ctl.oe[1], pad_ctl.out[1]}, 2'h2)
    rd(OFS_OD_STS, v); `CHK(v, 32'h2)
    wr(OFS_FSEL_LO, 32'h10); wr(OFS_FSEL_HI, 32'h0); wr(OFS_OD_EN, 32'h10);
    settle; `CHK({pad_ctl.oe[4], pad_ctl.out[4]}, 2'h0)
  endtask : t_od
  task t_pin;
    wr(OFS_OE_EN, 32'h40); ext_low[5] <= 1'b1; repeat (10) settle;
    rd(OFS_PIN_LVL, v); `CHK(v & 32'h60, 32'h0)
    `CHK(periph_in[6:5], 2'h0)
    @(posedge sys_clk) samp_clk_en <= 1'b0;
    ext_low[5] <= 1'b0;
    repeat (10) settle;
    `CHK(periph_in[6:5], 2'h1)
    rd(OFS_PIN_LVL, v); `CHK(v & 32'h60, 32'h0)
    // configuration must still land with sampling stopped
    wr(OFS_OD_DIS, 32'h2); rd(OFS_OD_STS, v); `CHK(v, 32'h10)
    @(posedge sys_clk) samp_clk_en <= 1'b1;
    repeat (10) settle;
    rd(OFS_PIN_LVL, v); `CHK(v & 32'h60, 32'h20)
  endtask : t_pin
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // each function drives a distinct oe/out pair on every line
  initial begin
    for (int k = 0; k < NFUNC; k++) begin
      periph_drv[k].out = {NLINES{k[0]}};
      periph_drv[k].oe = {NLINES{~k[1]}};
    end
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset; t_pull; t_func; t_out; t_od; t_pin;
    final_report;
  end
  // the run needs well under two thousand cycles
  initial begin
    #20000 n_mismatch++;
    final_report;
  end
endmodule : io_line_controller_core_test
`default_nettype wire

// ---- test/iolc_core_properties.sv ----
// checker: port-level properties of the io line controller core
// assumes: bound onto iolc_core; one clock, rstn low resets all state
`timescale 1ns/10ps
`default_nettype none
module iolc_core_properties
  import iolc_pkg::*;
(
  input wire iolc_pkg::iolc_bus_req_t bus_req,
  input wire logic                    sys_clk,
  input wire logic                    rstn,
  input wire logic [31:0]             bus_rdata,
  input wire logic [NLINES-1:0]       periph_in,
  input wire logic [NLINES-1:0]       pad_in,
  input wire iolc_pkg::iolc_pad_t     pad_ctl
);
  logic [31:0] pu;
  logic [31:0] pd;
  logic [31:0] wd;
  // short names keep each property within two lines
  assign pu = pad_ctl.pu_en;
  assign pd = pad_ctl.pd_en;
  assign wd = bus_req.wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // one strobe cycle aimed at a given offset
  sequence wr_at(logic [7:0] a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // pull enables may never override the opposite pull
  pu_dis_a: assert property (wr_at(OFS_PU_DIS) |=> !(pu & $past(wd)))
    else $error("pull-up still on after disable");
  pu_en_a: assert property (wr_at(OFS_PU_EN) |=>
    (~pu & $past(wd) & ~$past(pd)) == 0)
    else $error("pull-up enable lost");
  pu_excl_a: assert property (wr_at(OFS_PU_EN) |=>
    ((pu ^ $past(pu)) & $past(pd)) == 0)
    else $error("pull-up moved beside active pull-down");
  pd_dis_a: assert property (wr_at(OFS_PD_DIS) |=> !(pd & $past(wd)))
    else $error("pull-down still on after disable");
  pd_excl_a: assert property (wr_at(OFS_PD_EN) |=>
    ((pd ^ $past(pd)) & $past(pu)) == 0)
    else $error("pull-down moved beside active pull-up");
  pu_sts_a: assert property (rd_at(OFS_PU_STS) |=>
    bus_rdata == ~$past(pu))
    else $error("pull-up status read wrong");
  rst_pull_a: assert property ($rose(rstn) |->
    pu == 32'hFFFF_FFFF && pd == 32'hF000_0000)
    else $error("pull state wrong after reset");
  rst_drive_a: assert property ($rose(rstn) |->
    pad_ctl.oe == 0 && pad_ctl.out == 0)
    else $error("pad driven after reset");
  pass_in_a: assert property (periph_in == pad_in)
    else $error("peripheral input differs from pad");
endmodule : iolc_core_properties

bind iolc_core iolc_core_properties chk_u (
  .bus_req   (bus_req),
  .sys_clk   (sys_clk),
  .rstn      (rstn),
  .bus_rdata (bus_rdata),
  .periph_in (periph_in),
  .pad_in    (pad_in),
  .pad_ctl   (pad_ctl)
);
`default_nettype wire

// ---- test/iolc_pads.sv ----
// pads: pin level seen outside, from pad drive, an outside low driver
// and the pulls; assumes the outside driver is open-drain
`timescale 1ns/10ps
`default_nettype none
module iolc_pads
  import iolc_pkg::*;
(
  input wire logic                sys_clk,
  input wire iolc_pkg::iolc_pad_t pad_ctl,
  input wire logic [NLINES-1:0]   ext_low,
  output var logic [NLINES-1:0]   pad_in
);
  logic [NLINES-1:0] float_ff = '0;
  // a floating pin wanders so a stale value never looks right
  always_ff @(posedge sys_clk) begin
    float_ff <= ~float_ff;
  end
  // drive wins, then outside low, then pull-up, then pull-down, else float
  always_comb begin
    for (int i = 0; i < NLINES; i++) begin
      if (pad_ctl.oe[i]) pad_in[i] = pad_ctl.out[i];
      else if (ext_low[i]) pad_in[i] = 1'b0;
      else if (pad_ctl.pu_en[i]) pad_in[i] = 1'b1;
      else if (pad_ctl.pd_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_ff[i];
    end
  end
endmodule : iolc_pads
`default_nettype wire
